/* File: include/dduc_pkg.sv */
// Shared constants and types of the dual converter update and reset control
package dduc_pkg;
	localparam int FRAME_BITS = 24;
	localparam int CNT_W = 5;
	localparam int DATA_W = 16;
	localparam int NUM_CH = 2;
	localparam int PIN_W = 6;
	localparam logic [CNT_W-1:0] FRAME_CNT = 5'h18;
	localparam logic [3:0] CMD_WR_IN = 4'h1;
	localparam logic [3:0] CMD_UPD = 4'h2;
	localparam logic [3:0] CMD_WR_UPD = 4'h3;
	localparam logic [3:0] CMD_MASK = 4'h5;
	localparam logic [3:0] CMD_SW_RST = 4'h6;
	localparam logic [3:0] CMD_REF = 4'h7;
	localparam int CH_A_BIT = 0;
	localparam int CH_B_BIT = 3;
	localparam int REF_BIT = 0;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic REF_ON_RST = 1'b1;
	// Pin bundle positions and reset levels of the pin synchroniser
	localparam int PIN_SCLK = 0;
	localparam int PIN_SYNC = 1;
	localparam int PIN_SDIN = 2;
	localparam int PIN_STROBE = 3;
	localparam int PIN_RESET_LEVEL_SELECT = 4;
	localparam int PIN_HWRST = 5;
	localparam logic [PIN_W-1:0] PIN_RST_VAL = 6'h0A;

	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [15:0] data;
	} dduc_frame_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_INIT = 3'b010,
		ST_RUN = 3'b100
	} dduc_state_t;
endpackage

/* File: rtl/dduc_sync.sv */
// Two-stage synchroniser for a bundle of pins
`timescale 1ns/1ps
module dduc_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : bitSync
			logic meta_r;
			logic stable_r;
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					meta_r <= RST_VAL[i];
					stable_r <= RST_VAL[i];
				end else begin
					meta_r <= pinIn[i];
					stable_r <= meta_r;
				end
			end
			assign pinOut[i] = stable_r;
		end
	endgenerate
endmodule

/* File: rtl/dduc_ctrl.sv */
// Update, mask, reset and reference control of a dual-channel converter
`timescale 1ns/1ps
module dduc_ctrl #(
	parameter int DW = dduc_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic syncN,
	input wire logic sdin,
	input wire logic loadUpdateStrobeN,
	input wire logic resetLevelSelect,
	input wire logic hwResetN,
	output logic [DW-1:0] dacCodeA,
	output logic [DW-1:0] dacCodeB,
	output logic [3:0] updateMask,
	output logic refEnable,
	output logic ready
);
	import dduc_pkg::*;

	logic [PIN_W-1:0] pinRaw;
	logic [PIN_W-1:0] pinS;
	logic sclkS;
	logic syncS;
	logic sdinS;
	logic strobeNS;
	logic rstselS;
	logic hwRstNS;

	assign pinRaw = {hwResetN, resetLevelSelect, loadUpdateStrobeN, sdin, syncN, sclk};

	dduc_sync #(
		.W(PIN_W),
		.RST_VAL(PIN_RST_VAL)
	) pinSync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn(pinRaw),
		.pinOut(pinS)
	);

	assign sclkS = pinS[PIN_SCLK];
	assign syncS = pinS[PIN_SYNC];
	assign sdinS = pinS[PIN_SDIN];
	assign strobeNS = pinS[PIN_STROBE];
	assign rstselS = pinS[PIN_RESET_LEVEL_SELECT];
	assign hwRstNS = pinS[PIN_HWRST];

	// Edge detection on synchronised pins
	logic sclkPrev_r;
	logic syncPrev_r;
	logic strobePrev_r;
	logic sclkFall;
	logic syncRise;
	logic strobeFall;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclkPrev_r <= 1'b0;
			syncPrev_r <= 1'b1;
			strobePrev_r <= 1'b1;
		end else begin
			sclkPrev_r <= sclkS;
			syncPrev_r <= syncS;
			strobePrev_r <= strobeNS;
		end
	end

	assign sclkFall = sclkPrev_r & ~sclkS;
	assign syncRise = syncS & ~syncPrev_r;
	assign strobeFall = strobePrev_r & ~strobeNS;

	// Frame capture: shift on clock falling edges while sync is low
	logic [FRAME_BITS-1:0] shift_r;
	logic [FRAME_BITS-1:0] shift_nxt;
	logic [CNT_W-1:0] bitCnt_r;
	logic [CNT_W-1:0] bitCnt_nxt;
	dduc_frame_t frame;
	logic frameDone;

	assign shift_nxt = (!syncS && sclkFall) ? {shift_r[FRAME_BITS-2:0], sdinS} : shift_r;
	assign bitCnt_nxt = syncS ? '0 :
		((sclkFall && bitCnt_r != FRAME_CNT) ? bitCnt_r + 5'h01 : bitCnt_r);
	// Frame taken on sync rising edge after 24 or more bits
	assign frameDone = syncRise && (bitCnt_r == FRAME_CNT);
	assign frame = dduc_frame_t'(shift_r);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_r <= '0;
			bitCnt_r <= '0;
		end else begin
			shift_r <= shift_nxt;
			bitCnt_r <= bitCnt_nxt;
		end
	end

	// Power-on sequencing
	dduc_state_t state_r;
	dduc_state_t state_nxt;
	logic running;
	logic initLoad;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_WAIT: begin
				if (hwRstNS) begin
					state_nxt = ST_INIT;
				end
			end
			ST_INIT: begin
				state_nxt = ST_RUN;
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_WAIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign running = (state_r == ST_RUN);
	assign initLoad = (state_r == ST_INIT);

	// Command decode
	logic frameExec;
	logic cmdMask;
	logic cmdSwRst;
	logic cmdRef;
	logic clearAll;
	logic hwRstLow;
	logic [DW-1:0] clrCode;
	logic [DW-1:0] midCode;

	assign frameExec = frameDone && running;
	assign cmdMask = frameExec && (frame.cmd == CMD_MASK);
	assign cmdSwRst = frameExec && (frame.cmd == CMD_SW_RST);
	assign cmdRef = frameExec && (frame.cmd == CMD_REF);
	assign hwRstLow = !hwRstNS;
	// Software reset or init loads power-on code
	assign clearAll = initLoad || cmdSwRst;
	assign midCode = {1'b1, {(DW-1){1'b0}}};
	assign clrCode = rstselS ? midCode : '0;

	// Mask and reference registers
	logic [3:0] mask_r;
	logic refEnable_r;
	logic ready_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= MASK_RST;
			refEnable_r <= REF_ON_RST;
			ready_r <= 1'b0;
		end else begin
			ready_r <= running;
			if (clearAll) begin
				mask_r <= MASK_RST;
				refEnable_r <= REF_ON_RST;
			end else begin
				if (cmdMask) begin
					mask_r <= frame.data[3:0];
				end
				if (cmdRef) begin
					refEnable_r <= ~frame.data[REF_BIT];
				end
			end
		end
	end

	// Per-channel input and output registers
	logic [DW-1:0] outCode [NUM_CH];
	logic [DW-1:0] inCode [NUM_CH];
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : chan
			// Channel A at bit 0, channel B at bit 3
			localparam int POS = (ch == 0) ? CH_A_BIT : CH_B_BIT;
			logic [DW-1:0] inReg_r;
			logic [DW-1:0] outReg_r;
			logic [DW-1:0] out_nxt;
			logic sel;
			logic wrIn;
			logic wrOut;
			logic strobeUpd;
			logic upd;

			assign sel = frameExec && frame.addr[POS];
			assign wrIn = sel && (frame.cmd == CMD_WR_IN || frame.cmd == CMD_WR_UPD);
			// Strobe low lets a write reach output
			assign wrOut = sel && ((frame.cmd == CMD_WR_IN && !strobeNS)
				|| frame.cmd == CMD_WR_UPD);
			// Unmasked falling edge in normal running
			assign strobeUpd = running && strobeFall && !mask_r[POS];
			assign upd = wrOut || (sel && frame.cmd == CMD_UPD) || strobeUpd;
			assign out_nxt = wrOut ? frame.data[DW-1:0] : inReg_r;

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					inReg_r <= '0;
					outReg_r <= '0;
				end else if (clearAll || (running && hwRstLow)) begin
					// Clear and block while reset pin low
					inReg_r <= clrCode;
					outReg_r <= clrCode;
				end else begin
					if (wrIn) begin
						inReg_r <= frame.data[DW-1:0];
					end
					// Output changes only on an update
					if (upd) begin
						outReg_r <= out_nxt;
					end
				end
			end

			assign outCode[ch] = outReg_r;
			assign inCode[ch] = inReg_r;
		end
	endgenerate

	assign dacCodeA = outCode[0];
	assign dacCodeB = outCode[1];
	assign updateMask = mask_r;
	assign refEnable = refEnable_r;
	assign ready = ready_r;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	logic [DW-1:0] outA;
	logic [DW-1:0] inA;
	logic quietA;
	assign outA = outCode[0];
	assign inA = inCode[0];
	assign quietA = running && hwRstNS && !frameDone;

	sequence strobeEdgeA;
		quietA && strobeFall;
	endsequence

	sequence writeA(logic [3:0] c);
		frameExec && hwRstNS && frame.addr[CH_A_BIT] && frame.cmd == c;
	endsequence

	mask_load_a: assert property (cmdMask && !clearAll |=> mask_r == $past(frame.data[3:0])) else $error("mask not loaded");
	mask_block_a: assert property (strobeEdgeA and mask_r[CH_A_BIT] |=> $stable(outA)) else $error("masked channel updated");
	strobe_upd_a: assert property (strobeEdgeA and !mask_r[CH_A_BIT] |=> outA == $past(inA)) else $error("strobe update missed");
	wr_hold_a: assert property (writeA(CMD_WR_IN) and strobeNS && !strobeFall |=> $stable(outA) && inA == $past(frame.data)) else $error("write reached output");
	wr_through_a: assert property (writeA(CMD_WR_IN) and !strobeNS |=> outA == $past(frame.data) && inA == outA) else $error("write not passed");
	upd_cmd_a: assert property (writeA(CMD_UPD) |=> outA == $past(inA) && $stable(inA)) else $error("update command wrong");
	wr_upd_a: assert property (writeA(CMD_WR_UPD) |=> outA == $past(frame.data) ##1
		($stable(outA) || $past(frameDone) || $past(hwRstLow) || $past(strobeFall)))
		else $error("write-update wrong");
	hw_clear_a: assert property ((running && hwRstLow) [*2] |-> outA == $past(clrCode)) else $error("reset pin clear wrong");
	sw_reset_a: assert property (cmdSwRst |=> outA == $past(clrCode) && mask_r == MASK_RST && refEnable_r) else $error("software reset wrong");
	// Initialisation held while reset pin low
	init_hold_a: assert property (state_r == ST_WAIT && hwRstLow |=> state_r == ST_WAIT && outA == '0) else $error("init not held");
	ref_set_a: assert property (cmdRef |=> refEnable_r == !$past(frame.data[REF_BIT])) else $error("reference bit wrong");
endmodule

/* File: testbench/dduc_host_model.sv */
// Host serial controller model that sends command frames
`timescale 1ns/1ps
module dduc_host_model (
	output logic sclk,
	output logic syncN,
	output logic sdin
);
	import dduc_pkg::*;
	initial begin
		sclk = 1'b1;
		syncN = 1'b1;
		sdin = 1'b0;
	end
	task automatic sendFrame(input dduc_pkg::dduc_frame_t f);
		logic [FRAME_BITS-1:0] bits;
		bits = f;
		syncN = 1'b0;
		#100;
		for (int i = FRAME_BITS - 1; i >= 0; i--) begin
			sdin = bits[i];
			#100 sclk = 1'b0;
			#100 sclk = 1'b1;
		end
		#100 syncN = 1'b1;
		// Released data line shows the inverse of the last bit
		sdin = ~sdin;
		#300;
	endtask
endmodule

/* File: testbench/dduc_ctrl_tb_top.sv */
// Self-checking bench of the converter update and reset control
`timescale 1ns/1ps
module dduc_ctrl_tb_top;
	import dduc_pkg::*;
	logic clk, reset_n, sclk, syncN, sdin, strobeN, levelSel, hwResetN, refOn, ready;
	logic [15:0] codeA, codeB;
	logic [3:0] mask;
	int miscompares = 0;
	int comparisons = 0;
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	dduc_ctrl i_dduc_ctrl (.clk(clk), .reset_n(reset_n), .sclk(sclk), .syncN(syncN),
		.sdin(sdin), .loadUpdateStrobeN(strobeN), .resetLevelSelect(levelSel),
		.hwResetN(hwResetN), .dacCodeA(codeA), .dacCodeB(codeB), .updateMask(mask),
		.refEnable(refOn), .ready(ready));
	dduc_host_model i_dduc_host_model (.sclk(sclk), .syncN(syncN), .sdin(sdin));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic codes(input logic [15:0] ea, input logic [15:0] eb);
		check(codeA, ea);
		check(codeB, eb);
	endtask
	task automatic settle();
		repeat (8) @(posedge clk);
		#2;
	endtask
	task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		i_dduc_host_model.sendFrame(dduc_frame_t'({c, a, d}));
		settle();
	endtask
	task automatic pulse();
		@(posedge clk);
		#2 strobeN = 1'b0;
		repeat (6) @(posedge clk);
		#2 strobeN = 1'b1;
		settle();
	endtask
	task automatic endTest(input string name);
		$display("Test %s finished, miscompares so far %0d", name, miscompares);
	endtask
	task automatic results();
		$display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		miscompares++;
		results();
	end
	initial begin
		reset_n = 1'b0;
		strobeN = 1'b1;
		levelSel = 1'b1;
		hwResetN = 1'b0;
		repeat (10) @(posedge clk);
		#2 reset_n = 1'b1;
		settle();
		check({15'h0000, ready}, 16'h0000);
		hwResetN = 1'b1;
		for (int i = 0; i < 40 && ready !== 1'b1; i++) @(posedge clk);
		settle();
		check({15'h0000, ready}, 16'h0001);
		codes(16'h8000, 16'h8000);
		check({12'h000, mask}, 16'h0000);
		check({15'h0000, refOn}, 16'h0001);
		endTest("powerup");
		frame(CMD_WR_IN, 4'h1, 16'h1234);
		frame(CMD_WR_IN, 4'h8, 16'h5678);
		codes(16'h8000, 16'h8000);
		pulse();
		codes(16'h1234, 16'h5678);
		endTest("deferred");
		frame(CMD_MASK, 4'hF, 16'hFFF8);
		check({12'h000, mask}, 16'h0008);
		frame(CMD_WR_IN, 4'h9, 16'hAAAA);
		pulse();
		codes(16'hAAAA, 16'h5678);
		frame(CMD_UPD, 4'h8, 16'h0000);
		codes(16'hAAAA, 16'hAAAA);
		frame(CMD_MASK, 4'h0, 16'h0001);
		check({12'h000, mask}, 16'h0001);
		endTest("mask");
		frame(CMD_WR_UPD, 4'h1, 16'h0F0F);
		codes(16'h0F0F, 16'hAAAA);
		strobeN = 1'b0;
		settle();
		frame(CMD_WR_IN, 4'h1, 16'h3C3C);
		codes(16'h3C3C, 16'hAAAA);
		strobeN = 1'b1;
		settle();
		endTest("direct");
		frame(CMD_REF, 4'hF, 16'h0001);
		check({15'h0000, refOn}, 16'h0000);
		frame(CMD_REF, 4'h0, 16'hFFFE);
		check({15'h0000, refOn}, 16'h0001);
		endTest("reference");
		levelSel = 1'b0;
		hwResetN = 1'b0;
		settle();
		codes(16'h0000, 16'h0000);
		frame(CMD_WR_UPD, 4'h9, 16'h1111);
		codes(16'h0000, 16'h0000);
		hwResetN = 1'b1;
		settle();
		pulse();
		codes(16'h0000, 16'h0000);
		endTest("hwreset");
		frame(CMD_WR_UPD, 4'h9, 16'h2222);
		frame(CMD_MASK, 4'h0, 16'h0009);
		frame(CMD_REF, 4'h0, 16'h0001);
		codes(16'h2222, 16'h2222);
		levelSel = 1'b1;
		frame(CMD_SW_RST, 4'h0, 16'h0000);
		codes(16'h8000, 16'h8000);
		check({12'h000, mask}, 16'h0000);
		check({15'h0000, refOn}, 16'h0001);
		endTest("swreset");
		results();
	end
endmodule
